// File: src/dlb_config_core.sv
// Purpose: register bank and control of a single-channel serial-display to LVDS bridge
// Assumes: register port is a byte bus synchronous to clk_sys, one access per cycle
// Notes: outputs are control levels for receiver, PLL and serializer
//
// Behaviour
// RULE_01 - host stops: PLL off, stream off, LP11
// RULE_02 - host restarts: stream, PLL, 3 ms, reset
// RULE_03 - flip bit reverses output pin order
// RULE_04 - interrupt needs status, mask and global enable
// RULE_05 - writing one clears status bit
// RULE_06 - errors may set around resets and streaming
// RULE_07 - host clears errors before restarting
// RULE_08 - host streams only after configuration
// RULE_09 - hs clock divided by divider field
// RULE_10 - host sets both range fields correctly
// RULE_11 - host enables PLL after clock setup
// RULE_12 - band code two is 62.5-87.5 MHz
// RULE_13 - source bit one selects hs clock
// RULE_14 - divider code 00101 divides by six
// RULE_15 - lane code 00 enables four lanes
// RULE_16 - input band 0x64 means 500 MHz
// RULE_17 - pattern bit starts test pattern generator
// RULE_18 - multiplier codes select times one to four
// RULE_19 - channel mode: dual, single, two singles
// RULE_20 - format bits: polarities, link, 24bpp
// RULE_21 - channel bit0 disables leader error tolerance
// RULE_22 - host derives porches from panel timing
// RULE_23 - interrupt pin floats unless globally enabled
// RULE_24 - PLL lock loss sets unlock flag
// RULE_25 - timing values: low byte, then high byte
// RULE_26 - flags and interrupt hold until cleared
`timescale 1ns/1ps
`default_nettype none
`include "dlb_defines.svh"

module dlb_config_core
    import dlb_pkg::*;
#(
    parameter int PLL_WAIT_CYCLES = 8
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // events from receiver and PLL
    input wire logic pll_lock,
    input wire logic [7:0] err_event,
    // interrupt pin
    output logic irq_out,
    output logic irq_oe,
    // control levels to datapath
    output logic soft_reset_pulse,
    output logic pll_enable,
    output logic pixel_clock_source_select,
    output logic [4:0] div_factor,
    output logic [2:0] mult_factor,
    output logic [2:0] lvds_band,
    output logic [7:0] input_clock_band,
    output logic [1:0] ch_mode,
    output logic [3:0] input_lane_count,
    output logic leader_error_tolerance_off,
    output logic data_enable_polarity,
    output logic hsync_polarity,
    output logic vsync_polarity,
    output logic link_config,
    output logic cha_24bpp,
    output logic output_pin_order_flip,
    output logic pattern_generator_enable,
    output logic [11:0] line_length,
    output logic [11:0] display_rows,
    output logic [11:0] sync_delay,
    output logic [7:0] hsync_width,
    output logic [11:0] vsync_width,
    output logic [7:0] horizontal_back_porch,
    output logic [7:0] vertical_back_porch,
    output logic [7:0] horizontal_front_porch,
    output logic [7:0] vertical_front_porch,
    output logic pll_locked
);

    dlb_state_t st_reg;
    dlb_state_t st_next;
    logic [15:0] wait_cnt_reg;
    logic [15:0] wait_cnt_next;

    always_comb
    begin
        logic [7:0] ev;
        logic [7:0] clr;
        ev = '0;
        clr = '0;
        st_next = st_reg;
        wait_cnt_next = wait_cnt_reg;
        st_next.soft_reset_pulse = 1'b0;
        st_next.soft_reset = `DLB_RST_ZERO;
        // register writes
        if (reg_wr)
        begin
            if (reg_addr == `DLB_OFF_SOFT_RESET)
            begin
                st_next.soft_reset_pulse = reg_wdata[`DLB_BIT_SOFT_RESET];
            end
            else if (reg_addr == `DLB_OFF_CLK_SRC_RANGE)
            begin
                st_next.clk_src_range = reg_wdata;
            end
            else if (reg_addr == `DLB_OFF_CLK_DIV_MULT)
            begin
                st_next.clk_div_mult = reg_wdata;
            end
            else if (reg_addr == `DLB_OFF_LOOP_ENABLE)
            begin
                st_next.loop_enable = reg_wdata;
            end
            else if (reg_addr == `DLB_OFF_IN_CH_CFG)
            begin
                st_next.in_ch_cfg = reg_wdata;
            end
            else if (reg_addr == `DLB_OFF_IN_CLK_RANGE)
            begin
                st_next.in_clk_range = reg_wdata;
            end
            else if (reg_addr == `DLB_OFF_OUT_FORMAT)
            begin
                st_next.out_format = reg_wdata;
            end
            else if (reg_addr == `DLB_OFF_OUT_PIN_OPT)
            begin
                st_next.out_pin_opt = reg_wdata;
            end
            else if (reg_addr == `DLB_OFF_LINE_LEN_LO)
            begin
                st_next.line_len_lo = reg_wdata;
            end
            else if (reg_addr == `DLB_OFF_LINE_LEN_HI)
            begin
                st_next.line_len_hi = reg_wdata;
            end
            else if (reg_addr == `DLB_OFF_ROWS_LO)
            begin
                st_next.rows_lo = reg_wdata;
            end
            else if (reg_addr == `DLB_OFF_ROWS_HI)
            begin
                st_next.rows_hi = reg_wdata;
            end
            else if (reg_addr == `DLB_OFF_SYNC_DLY_LO)
            begin
                st_next.sync_dly_lo = reg_wdata;
            end
            else if (reg_addr == `DLB_OFF_SYNC_DLY_HI)
            begin
                st_next.sync_dly_hi = reg_wdata;
            end
            else if (reg_addr == `DLB_OFF_HSW_LO)
            begin
                st_next.hsw_lo = reg_wdata;
            end
            else if (reg_addr == `DLB_OFF_VSW_LO)
            begin
                st_next.vsw_lo = reg_wdata;
            end
            else if (reg_addr == `DLB_OFF_VSW_HI)
            begin
                st_next.vsw_hi = reg_wdata;
            end
            else if (reg_addr == `DLB_OFF_HBP) st_next.hbp = reg_wdata;
            else if (reg_addr == `DLB_OFF_VBP) st_next.vbp = reg_wdata;
            else if (reg_addr == `DLB_OFF_HFP) st_next.hfp = reg_wdata;
            else if (reg_addr == `DLB_OFF_VFP) st_next.vfp = reg_wdata;
            else if (reg_addr == `DLB_OFF_PATTERN) st_next.pattern = reg_wdata;
            else if (reg_addr == `DLB_OFF_IRQ_OUT_EN)
            begin
                st_next.irq_out_en = reg_wdata;
            end
            else if (reg_addr == `DLB_OFF_IRQ_MASK)
            begin
                st_next.irq_mask = reg_wdata & `DLB_ERR_IMPL_MASK;
            end
            else if (reg_addr == `DLB_OFF_ERR_STATUS)
            begin
                clr = reg_wdata; // RULE_05
            end
        end
        // lock loss sets the unlock flag; new events win over a clear
        ev = err_event;
        ev[`DLB_BIT_PLL_UNLOCK] = st_reg.pll_lock_prev & ~pll_lock; // RULE_24
        st_next.pll_lock_prev = pll_lock;
        st_next.err_status = ((st_reg.err_status & ~clr) | ev) & `DLB_ERR_IMPL_MASK; // RULE_05 RULE_06 RULE_26
        // PLL start-up: enable, wait, then report locked
        case (st_reg.pll_state)
            DLB_PLL_OFF:
            begin
                wait_cnt_next = '0;
                if (st_next.loop_enable[`DLB_BIT_PLL_EN])
                begin
                    st_next.pll_state = DLB_PLL_WAIT;
                end
            end
            DLB_PLL_WAIT:
            begin
                wait_cnt_next = wait_cnt_reg + 16'h0001;
                if (!st_next.loop_enable[`DLB_BIT_PLL_EN])
                begin
                    st_next.pll_state = DLB_PLL_OFF;
                end
                else if (wait_cnt_reg == 16'(PLL_WAIT_CYCLES - 1))
                begin
                    st_next.pll_state = DLB_PLL_LOCKED;
                end
            end
            DLB_PLL_LOCKED:
            begin
                wait_cnt_next = '0;
                if (!st_next.loop_enable[`DLB_BIT_PLL_EN])
                begin
                    st_next.pll_state = DLB_PLL_OFF;
                end
            end
            default:
            begin
                st_next.pll_state = DLB_PLL_OFF;
            end
        endcase
        // interrupt pin: floats unless globally enabled, high on enabled pending flag
        st_next.irq_oe = st_next.irq_out_en[`DLB_BIT_IRQ_OUT_EN]; // RULE_23
        st_next.irq_out = st_next.irq_out_en[`DLB_BIT_IRQ_OUT_EN]
            & (|(st_next.err_status & st_next.irq_mask)); // RULE_04 RULE_26
        // decoded control fields
        st_next.pixel_src_hs = st_next.clk_src_range[`DLB_BIT_CLK_SRC]; // RULE_13
        st_next.lvds_band = st_next.clk_src_range[`DLB_MSB_LVDS_RANGE:`DLB_LSB_LVDS_RANGE]; // RULE_12
        // divide ratio is code plus one, so 00101 divides by six
        st_next.div_factor = st_next.clk_div_mult[`DLB_MSB_DIV:`DLB_LSB_DIV]
            + `DLB_DIV_OFFSET; // RULE_09 RULE_14
        st_next.mult_factor = {1'b0, st_next.clk_div_mult[`DLB_MSB_MULT:`DLB_LSB_MULT]}
            + `DLB_MULT_OFFSET; // RULE_18
        st_next.ch_mode = st_next.in_ch_cfg[`DLB_MSB_CH_MODE:`DLB_LSB_CH_MODE]; // RULE_19
        // lane code n enables 4-n lanes, code 00 all four
        case (st_next.in_ch_cfg[`DLB_MSB_LANES:`DLB_LSB_LANES])
            2'b00: st_next.lane_enable = 4'b1111; // RULE_15
            2'b01: st_next.lane_enable = 4'b0111;
            2'b10: st_next.lane_enable = 4'b0011;
            default: st_next.lane_enable = 4'b0001;
        endcase
        st_next.leader_error_tolerance_off = st_next.in_ch_cfg[`DLB_BIT_SOT_TOL_OFF]; // RULE_21
        st_next.in_band = st_next.in_clk_range; // RULE_16
        st_next.pin_order_flip = st_next.out_pin_opt[`DLB_BIT_PIN_FLIP]; // RULE_03
        st_next.pattern_on = st_next.pattern[`DLB_BIT_PATTERN]; // RULE_17
        st_next.line_length = {st_next.line_len_hi[3:0], st_next.line_len_lo}; // RULE_25
        st_next.display_rows = {st_next.rows_hi[3:0], st_next.rows_lo}; // RULE_25
        st_next.sync_delay = {st_next.sync_dly_hi[3:0], st_next.sync_dly_lo}; // RULE_25
        st_next.vsync_width = {st_next.vsw_hi[3:0], st_next.vsw_lo}; // RULE_25
        // read data, registered; unmapped reads return zero
        st_next.rdata = `DLB_RST_ZERO;
        if (reg_rd)
        begin
            if (reg_addr == `DLB_OFF_CLK_SRC_RANGE) st_next.rdata = st_reg.clk_src_range;
            else if (reg_addr == `DLB_OFF_CLK_DIV_MULT) st_next.rdata = st_reg.clk_div_mult;
            else if (reg_addr == `DLB_OFF_LOOP_ENABLE) st_next.rdata = st_reg.loop_enable;
            else if (reg_addr == `DLB_OFF_IN_CH_CFG) st_next.rdata = st_reg.in_ch_cfg;
            else if (reg_addr == `DLB_OFF_IN_CLK_RANGE) st_next.rdata = st_reg.in_clk_range;
            else if (reg_addr == `DLB_OFF_OUT_FORMAT) st_next.rdata = st_reg.out_format;
            else if (reg_addr == `DLB_OFF_OUT_PIN_OPT) st_next.rdata = st_reg.out_pin_opt;
            else if (reg_addr == `DLB_OFF_LINE_LEN_LO) st_next.rdata = st_reg.line_len_lo;
            else if (reg_addr == `DLB_OFF_LINE_LEN_HI) st_next.rdata = st_reg.line_len_hi;
            else if (reg_addr == `DLB_OFF_ROWS_LO) st_next.rdata = st_reg.rows_lo;
            else if (reg_addr == `DLB_OFF_ROWS_HI) st_next.rdata = st_reg.rows_hi;
            else if (reg_addr == `DLB_OFF_SYNC_DLY_LO) st_next.rdata = st_reg.sync_dly_lo;
            else if (reg_addr == `DLB_OFF_SYNC_DLY_HI) st_next.rdata = st_reg.sync_dly_hi;
            else if (reg_addr == `DLB_OFF_HSW_LO) st_next.rdata = st_reg.hsw_lo;
            else if (reg_addr == `DLB_OFF_VSW_LO) st_next.rdata = st_reg.vsw_lo;
            else if (reg_addr == `DLB_OFF_VSW_HI) st_next.rdata = st_reg.vsw_hi;
            else if (reg_addr == `DLB_OFF_HBP) st_next.rdata = st_reg.hbp;
            else if (reg_addr == `DLB_OFF_VBP) st_next.rdata = st_reg.vbp;
            else if (reg_addr == `DLB_OFF_HFP) st_next.rdata = st_reg.hfp;
            else if (reg_addr == `DLB_OFF_VFP) st_next.rdata = st_reg.vfp;
            else if (reg_addr == `DLB_OFF_PATTERN) st_next.rdata = st_reg.pattern;
            else if (reg_addr == `DLB_OFF_IRQ_OUT_EN) st_next.rdata = st_reg.irq_out_en;
            else if (reg_addr == `DLB_OFF_IRQ_MASK) st_next.rdata = st_reg.irq_mask;
            else if (reg_addr == `DLB_OFF_ERR_STATUS) st_next.rdata = st_reg.err_status;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            st_reg <= '0;
            st_reg.in_ch_cfg <= `DLB_RST_CH_CFG;
            st_reg.err_status <= `DLB_RST_ERR_STATUS;
            st_reg.ch_mode <= `DLB_RST_CH_MODE;
            st_reg.div_factor <= `DLB_DIV_OFFSET;
            st_reg.mult_factor <= `DLB_MULT_OFFSET;
            st_reg.lane_enable <= `DLB_RST_LANES;
            st_reg.pll_state <= DLB_PLL_OFF;
            wait_cnt_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
            wait_cnt_reg <= wait_cnt_next;
        end
    end

    assign reg_rdata = st_reg.rdata;
    assign irq_out = st_reg.irq_out;
    assign irq_oe = st_reg.irq_oe;
    assign soft_reset_pulse = st_reg.soft_reset_pulse;
    assign pll_enable = st_reg.loop_enable[`DLB_BIT_PLL_EN];
    assign pixel_clock_source_select = st_reg.pixel_src_hs;
    assign div_factor = st_reg.div_factor;
    assign mult_factor = st_reg.mult_factor;
    assign lvds_band = st_reg.lvds_band;
    assign input_clock_band = st_reg.in_band;
    assign ch_mode = st_reg.ch_mode;
    assign input_lane_count = st_reg.lane_enable;
    assign leader_error_tolerance_off = st_reg.leader_error_tolerance_off;
    assign data_enable_polarity = st_reg.out_format[`DLB_BIT_DATA_ENABLE_POLARITY]; // RULE_20
    assign hsync_polarity = st_reg.out_format[`DLB_BIT_HSYNC_POLARITY]; // RULE_20
    assign vsync_polarity = st_reg.out_format[`DLB_BIT_VSYNC_POLARITY]; // RULE_20
    assign link_config = st_reg.out_format[`DLB_BIT_LINK_CFG]; // RULE_20
    assign cha_24bpp = st_reg.out_format[`DLB_BIT_CHA_24BPP]; // RULE_20
    assign output_pin_order_flip = st_reg.pin_order_flip;
    assign pattern_generator_enable = st_reg.pattern_on;
    assign line_length = st_reg.line_length;
    assign display_rows = st_reg.display_rows;
    assign sync_delay = st_reg.sync_delay;
    assign hsync_width = st_reg.hsw_lo;
    assign vsync_width = st_reg.vsync_width;
    assign horizontal_back_porch = st_reg.hbp;
    assign vertical_back_porch = st_reg.vbp;
    assign horizontal_front_porch = st_reg.hfp;
    assign vertical_front_porch = st_reg.vfp;
    assign pll_locked = (st_reg.pll_state == DLB_PLL_LOCKED);

endmodule : dlb_config_core
`default_nettype wire

// File: src/dlb_defines.svh
// Purpose: register offsets, field positions and reset values of the bridge configuration block
// Assumes: 8-bit register port, one access per cycle
// Notes: definitions only
`ifndef DLB_DEFINES_SVH
`define DLB_DEFINES_SVH

`define DLB_OFF_SOFT_RESET 8'h09
`define DLB_OFF_CLK_SRC_RANGE 8'h0A
`define DLB_OFF_CLK_DIV_MULT 8'h0B
`define DLB_OFF_LOOP_ENABLE 8'h0D
`define DLB_OFF_IN_CH_CFG 8'h10
`define DLB_OFF_IN_CLK_RANGE 8'h12
`define DLB_OFF_OUT_FORMAT 8'h18
`define DLB_OFF_OUT_PIN_OPT 8'h1A
`define DLB_OFF_LINE_LEN_LO 8'h20
`define DLB_OFF_LINE_LEN_HI 8'h21
`define DLB_OFF_ROWS_LO 8'h24
`define DLB_OFF_ROWS_HI 8'h25
`define DLB_OFF_SYNC_DLY_LO 8'h28
`define DLB_OFF_SYNC_DLY_HI 8'h29
`define DLB_OFF_HSW_LO 8'h2C
`define DLB_OFF_VSW_LO 8'h30
`define DLB_OFF_VSW_HI 8'h31
`define DLB_OFF_HBP 8'h34
`define DLB_OFF_VBP 8'h36
`define DLB_OFF_HFP 8'h38
`define DLB_OFF_VFP 8'h3A
`define DLB_OFF_PATTERN 8'h3C
`define DLB_OFF_IRQ_OUT_EN 8'hE0
`define DLB_OFF_IRQ_MASK 8'hE1
`define DLB_OFF_ERR_STATUS 8'hE5

`define DLB_BIT_SOFT_RESET 0
`define DLB_BIT_PLL_EN 0
`define DLB_BIT_CLK_SRC 0
`define DLB_MSB_LVDS_RANGE 3
`define DLB_LSB_LVDS_RANGE 1
`define DLB_MSB_DIV 7
`define DLB_LSB_DIV 3
`define DLB_MSB_MULT 1
`define DLB_LSB_MULT 0
`define DLB_MSB_CH_MODE 6
`define DLB_LSB_CH_MODE 5
`define DLB_MSB_LANES 4
`define DLB_LSB_LANES 3
`define DLB_BIT_SOT_TOL_OFF 0
`define DLB_BIT_DATA_ENABLE_POLARITY 7
`define DLB_BIT_HSYNC_POLARITY 6
`define DLB_BIT_VSYNC_POLARITY 5
`define DLB_BIT_LINK_CFG 4
`define DLB_BIT_CHA_24BPP 3
`define DLB_BIT_PIN_FLIP 5
`define DLB_BIT_PATTERN 4
`define DLB_BIT_IRQ_OUT_EN 0
`define DLB_BIT_PLL_UNLOCK 0

`define DLB_ERR_IMPL_MASK 8'hFD
`define DLB_RST_ZERO 8'h00
`define DLB_RST_ERR_STATUS 8'h01
`define DLB_RST_CH_CFG 8'h20
`define DLB_RST_CH_MODE 2'h1
`define DLB_RST_LANES 4'hF
`define DLB_DIV_OFFSET 5'h01
`define DLB_MULT_OFFSET 3'h1

`endif

// File: src/dlb_pkg.sv
// Purpose: shared types of the bridge configuration block
// Assumes: nothing beyond the defines header
// Notes: types only
package dlb_pkg;

    typedef enum logic [2:0]
    {
        DLB_PLL_OFF = 3'b001,
        DLB_PLL_WAIT = 3'b010,
        DLB_PLL_LOCKED = 3'b100
    } dlb_pll_state_t;

    typedef struct packed
    {
        logic [7:0] soft_reset;
        logic [7:0] clk_src_range;
        logic [7:0] clk_div_mult;
        logic [7:0] loop_enable;
        logic [7:0] in_ch_cfg;
        logic [7:0] in_clk_range;
        logic [7:0] out_format;
        logic [7:0] out_pin_opt;
        logic [7:0] line_len_lo;
        logic [7:0] line_len_hi;
        logic [7:0] rows_lo;
        logic [7:0] rows_hi;
        logic [7:0] sync_dly_lo;
        logic [7:0] sync_dly_hi;
        logic [7:0] hsw_lo;
        logic [7:0] vsw_lo;
        logic [7:0] vsw_hi;
        logic [7:0] hbp;
        logic [7:0] vbp;
        logic [7:0] hfp;
        logic [7:0] vfp;
        logic [7:0] pattern;
        logic [7:0] irq_out_en;
        logic [7:0] irq_mask;
        logic [7:0] err_status;
        logic [7:0] rdata;
        logic pll_lock_prev;
        logic irq_out;
        logic irq_oe;
        logic soft_reset_pulse;
        logic pixel_src_hs;
        logic [4:0] div_factor;
        logic [2:0] mult_factor;
        logic [2:0] lvds_band;
        logic [1:0] ch_mode;
        logic [3:0] lane_enable;
        logic [7:0] in_band;
        logic pin_order_flip;
        logic pattern_on;
        logic leader_error_tolerance_off;
        logic [11:0] line_length;
        logic [11:0] display_rows;
        logic [11:0] sync_delay;
        logic [11:0] vsync_width;
        dlb_pll_state_t pll_state;
    } dlb_state_t;

endpackage : dlb_pkg

// File: verification/dlb_core_assertions.sv
// Purpose: port-level assertions of the bridge configuration block
// Assumes: one clock domain, synchronous active-low reset
// Notes: bound into dlb_config_core below
`timescale 1ns/1ps
`default_nettype none

module dlb_core_assertions
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // register port
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    // interrupt pin
    input wire logic irq_out,
    input wire logic irq_oe,
    // control levels
    input wire logic soft_reset_pulse,
    input wire logic pixel_clock_source_select,
    input wire logic [4:0] div_factor,
    input wire logic [2:0] mult_factor,
    input wire logic [2:0] lvds_band,
    input wire logic [3:0] input_lane_count,
    input wire logic output_pin_order_flip,
    input wire logic pattern_generator_enable
);
    logic [7:0] wd_q;

    // write data of the previous edge, compared against the decoded levels
    always_ff @(posedge clk_sys)
        wd_q <= reg_wdata;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    irq_float_a: assert property (reg_wr && reg_addr == 8'hE0 |=> irq_oe == wd_q[0])
        else $error("irq drive enable wrong");
    pin_flip_a: assert property (reg_wr && reg_addr == 8'h1A |=> output_pin_order_flip == wd_q[5])
        else $error("pin flip wrong");
    reset_pulse_a: assert property ((reg_wr && reg_addr == 8'h09 && reg_wdata[0]) ##1 !reg_wr
        |-> soft_reset_pulse ##1 !soft_reset_pulse)
        else $error("soft reset pulse wrong");
    no_stray_pulse_a: assert property (!(reg_wr && reg_addr == 8'h09) |=> !soft_reset_pulse)
        else $error("stray soft reset pulse");
    div_map_a: assert property (reg_wr && reg_addr == 8'h0B |=> div_factor == wd_q[7:3] + 5'h01)
        else $error("divider factor wrong");
    mult_map_a: assert property (reg_wr && reg_addr == 8'h0B |=> mult_factor == {1'b0, wd_q[1:0]} + 3'h1)
        else $error("multiplier factor wrong");
    src_band_a: assert property (reg_wr && reg_addr == 8'h0A
        |=> pixel_clock_source_select == wd_q[0] && lvds_band == wd_q[3:1])
        else $error("clock source or band wrong");
    lane_map_a: assert property (reg_wr && reg_addr == 8'h10 && reg_wdata[4:3] == 2'b00
        |=> input_lane_count == 4'hF)
        else $error("lane code zero wrong");
    pattern_a: assert property (reg_wr && reg_addr == 8'h3C |=> pattern_generator_enable == wd_q[4])
        else $error("pattern enable wrong");

    cover property (irq_out && irq_oe);
    cover property (soft_reset_pulse);
    cover property (reg_wr && reg_addr == 8'hE5);
endmodule : dlb_core_assertions

bind dlb_config_core dlb_core_assertions u_chk (.*);

`default_nettype wire

// File: verification/dlb_far_side_model.sv
// Purpose: behavioural PLL and receiver error source beside the bridge
// Assumes: lock comes a fixed count after enable
// Notes: error pulses are requested by the testbench
`timescale 1ns/1ps
`default_nettype none

module dlb_far_side_model
#(
    parameter int LOCK_DELAY = 4
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // from the bridge
    input wire logic pll_enable,
    // testbench requests
    input wire logic [7:0] err_req,
    // to the bridge
    output logic pll_lock,
    output logic [7:0] err_event
);
    int lock_cnt;

    always @(posedge clk_sys)
    begin
        err_event <= err_req;
        // lock drops with the enable, giving the unlock event
        if (!rst_b || !pll_enable)
        begin
            lock_cnt <= 0;
            pll_lock <= 1'b0;
        end
        else if (lock_cnt < LOCK_DELAY)
            lock_cnt <= lock_cnt + 1;
        else
            pll_lock <= 1'b1;
    end
endmodule : dlb_far_side_model

`default_nettype wire

// File: verification/tb_top.sv
// Purpose: self-checking bench of the bridge configuration block
// Assumes: byte register port
// Notes: expected values from the register layout
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] err_req = 8'h00;
    logic [7:0] reg_rdata, err_event, input_clock_band, hsync_width;
    logic [7:0] horizontal_back_porch, vertical_back_porch;
    logic [7:0] horizontal_front_porch, vertical_front_porch;
    logic pll_lock, irq_out, irq_oe, soft_reset_pulse, pll_enable, pixel_clock_source_select;
    logic leader_error_tolerance_off, data_enable_polarity, hsync_polarity, vsync_polarity;
    logic link_config, cha_24bpp, output_pin_order_flip, pattern_generator_enable, pll_locked;
    logic [4:0] div_factor;
    logic [2:0] mult_factor, lvds_band;
    logic [1:0] ch_mode;
    logic [3:0] input_lane_count;
    logic [11:0] line_length, display_rows, sync_delay, vsync_width;
    int miscompares = 0;
    int total_checks = 0;
    logic [15:0] init_seq [21] = '{16'h0A05, 16'h0B28, 16'h1026, 16'h1264, 16'h1872,
        16'h2000, 16'h2105, 16'h2420, 16'h2503, 16'h2820, 16'h2901, 16'h2C80, 16'h3007,
        16'h3100, 16'h34C0, 16'h3614, 16'h3840, 16'h3A03, 16'h1A20, 16'h3C10, 16'h0D01};

    dlb_config_core #(.PLL_WAIT_CYCLES(2)) dut (.*);

    dlb_far_side_model far (.clk_sys, .rst_b, .pll_enable, .err_req, .pll_lock, .err_event);

    always #50 clk_sys = ~clk_sys;

    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(what, 12'(exp), 12'(reg_rdata));
    endtask : rd

    task automatic fire(input logic [7:0] e);
        @(posedge clk_sys);
        err_req <= e;
        @(posedge clk_sys);
        err_req <= 8'h00;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : fire

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    initial
    begin
        repeat (5000) @(posedge clk_sys);
        miscompares++;
        report_and_stop();
    end

    initial
    begin
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd(8'hE5, 8'h01, "status");
        rd(8'h10, 8'h20, "channel cfg");
        rd(8'h09, 8'h00, "reset reg");
        wr(8'hFF, 8'h5A);
        rd(8'hFF, 8'h00, "unmapped");
        chk("div", 12'h001, 12'(div_factor));
        chk("lanes", 12'h00F, 12'(input_lane_count));
        chk("irq_oe", 12'h000, 12'(irq_oe));
        $display("test reset done");
        foreach (init_seq[i]) wr(init_seq[i][15:8], init_seq[i][7:0]);
        chk("src", 12'h001, 12'(pixel_clock_source_select));
        chk("band", 12'h002, 12'(lvds_band));
        chk("div", 12'h006, 12'(div_factor));
        chk("lanes", 12'h00F, 12'(input_lane_count));
        chk("in band", 12'h064, 12'(input_clock_band));
        chk("format", 12'h00E, 12'({data_enable_polarity, hsync_polarity, vsync_polarity,
            link_config, cha_24bpp}));
        chk("line", 12'h500, line_length);
        chk("rows", 12'h320, display_rows);
        chk("sync", 12'h120, sync_delay);
        chk("hsw", 12'h080, 12'(hsync_width));
        chk("vsw", 12'h007, vsync_width);
        chk("pll en", 12'h001, 12'(pll_enable));
        chk("hbp", 12'h0C0, 12'(horizontal_back_porch));
        chk("vbp", 12'h014, 12'(vertical_back_porch));
        chk("hfp", 12'h040, 12'(horizontal_front_porch));
        chk("vfp", 12'h003, 12'(vertical_front_porch));
        chk("flip", 12'h001, 12'(output_pin_order_flip));
        chk("pattern", 12'h001, 12'(pattern_generator_enable));
        rd(8'h0B, 8'h28, "divider reg");
        $display("test configuration done");
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h0B, {5'h05, 1'b0, i[1:0]});
            chk("mult", 12'(i + 1), 12'(mult_factor));
        end
        for (int i = 0; i < 3; i++)
        begin
            wr(8'h10, {1'b0, i[1:0], 4'h0, i[0]});
            chk("mode", 12'(i), 12'(ch_mode));
            chk("leader", 12'(i % 2), 12'(leader_error_tolerance_off));
        end
        wr(8'h10, 8'h26);
        $display("test codes done");
        wr(8'hE5, 8'hFF);
        rd(8'hE5, 8'h00, "status clear");
        wr(8'hE1, 8'h40);
        fire(8'h40);
        chk("irq_oe", 12'h000, 12'(irq_oe));
        rd(8'hE5, 8'h40, "status set");
        wr(8'hE0, 8'h01);
        chk("irq_oe", 12'h001, 12'(irq_oe));
        chk("irq", 12'h001, 12'(irq_out));
        wr(8'hE5, 8'hBF);
        chk("irq held", 12'h001, 12'(irq_out));
        wr(8'hE1, 8'h00);
        chk("irq masked", 12'h000, 12'(irq_out));
        wr(8'hE1, 8'h40);
        wr(8'hE5, 8'h40);
        chk("irq cleared", 12'h000, 12'(irq_out));
        rd(8'hE5, 8'h00, "status");
        $display("test interrupt done");
        wr(8'h0D, 8'h00);
        repeat (4) @(posedge clk_sys);
        rd(8'hE5, 8'h01, "unlock flag");
        wr(8'hE5, 8'h01);
        wr(8'h0D, 8'h01);
        repeat (10) @(posedge clk_sys);
        #1;
        chk("locked", 12'h001, 12'(pll_locked));
        wr(8'h09, 8'h01);
        chk("soft reset", 12'h001, 12'(soft_reset_pulse));
        @(posedge clk_sys);
        #1;
        chk("soft reset end", 12'h000, 12'(soft_reset_pulse));
        wr(8'hE0, 8'h00);
        chk("irq_oe", 12'h000, 12'(irq_oe));
        $display("test restart done");
        report_and_stop();
    end
endmodule : tb_top

`default_nettype wire
